/* File: rtl/ro_reset_wdog.sv */
`timescale 1ns/1ps
`include "ro_cfg.svh"
module ro_reset_wdog #(
    parameter int TICK_CYCLES = `RO_TICK_NS / `RO_CLK_NS
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic power_down_active,
    input wire logic last_slot_delay_done,
    input wire logic [5:0] last_slot_channels,
    input wire logic [5:0] monitored_channel_above_uv,
    input wire logic [5:0] monitored_channel_uv_fault,
    input wire logic [5:0] monitored_channel_ov_fault,
    input wire logic [5:0] monitored_channel_critical,
    input wire logic supply_ok,
    input wire logic boot_done,
    input wire logic soft_reboot,
    input wire logic manual_reset_input_n,
    input wire logic enable_input,
    input wire logic watchdog_kick_input,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    output logic watchdog_expiry_output_n
);

    // pin synchronisers
    logic kick_s1, kick_s2, kick_s3;
    logic [2:0] kick_warm;
    logic en_s1, en_s2;
    logic mr_s1, mr_s2;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            kick_s1 <= 1'b0;
            kick_s2 <= 1'b0;
            kick_s3 <= 1'b0;
            kick_warm <= 3'b000;
            en_s1 <= 1'b0;
            en_s2 <= 1'b0;
            mr_s1 <= 1'b1;
            mr_s2 <= 1'b1;
        end else begin
            kick_s1 <= watchdog_kick_input;
            kick_s2 <= kick_s1;
            kick_s3 <= kick_s2;
            kick_warm <= {kick_warm[1:0], 1'b1};
            en_s1 <= enable_input;
            en_s2 <= en_s1;
            mr_s1 <= manual_reset_input_n;
            mr_s2 <= mr_s1;
        end
    end

    // pin level before reset is unknown; a false kick would cut the startup delay short
    wire kick_edge = kick_warm[2] && (kick_s2 ^ kick_s3);

    // 1us time base; all long periods count ticks so they stay narrow
    logic [7:0] tick_cnt;
    wire tick = (tick_cnt == 8'(TICK_CYCLES - 1));

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            tick_cnt <= 8'h00;
        else if (tick)
            tick_cnt <= 8'h00;
        else
            tick_cnt <= tick_cnt + 8'h01;
    end

    // period tables in microseconds
    function automatic logic [19:0] rp_us(input logic [3:0] code);
        case (code)
            4'h0: rp_us = 20'd25;
            4'h1: rp_us = 20'd1500;
            4'h2: rp_us = 20'd2500;
            4'h3: rp_us = 20'd4000;
            4'h4: rp_us = 20'd6000;
            4'h5: rp_us = 20'd10000;
            4'h6: rp_us = 20'd15000;
            4'h7: rp_us = 20'd25000;
            4'h8: rp_us = 20'd40000;
            4'h9: rp_us = 20'd60000;
            4'hA: rp_us = 20'd100000;
            4'hB: rp_us = 20'd150000;
            4'hC: rp_us = 20'd250000;
            4'hD: rp_us = 20'd400000;
            default: rp_us = 20'd1000000;
        endcase
    endfunction : rp_us

    function automatic logic [28:0] start_us(input logic [2:0] code);
        case (code)
            3'h1: start_us = 29'd30000000;
            3'h2: start_us = 29'd40000000;
            3'h3: start_us = 29'd80000000;
            3'h4: start_us = 29'd120000000;
            3'h5: start_us = 29'd160000000;
            3'h6: start_us = 29'd220000000;
            3'h7: start_us = 29'd300000000;
            default: start_us = 29'd0;
        endcase
    endfunction : start_us

    function automatic logic [28:0] wd_us(input logic [3:0] code);
        case (code)
            4'h1: wd_us = 29'd1000;
            4'h2: wd_us = 29'd2000;
            4'h3: wd_us = 29'd4000;
            4'h4: wd_us = 29'd8000;
            4'h5: wd_us = 29'd14000;
            4'h6: wd_us = 29'd27000;
            4'h7: wd_us = 29'd50000;
            4'h8: wd_us = 29'd100000;
            4'h9: wd_us = 29'd200000;
            4'hA: wd_us = 29'd400000;
            4'hB: wd_us = 29'd750000;
            4'hC: wd_us = 29'd1400000;
            4'hD: wd_us = 29'd2700000;
            4'hE: wd_us = 29'd5000000;
            4'hF: wd_us = 29'd10000000;
            default: wd_us = 29'd0;
        endcase
    endfunction : wd_us

    // registers
    logic [7:0] cfg;
    logic [5:0] uv_mask;
    logic [5:0] ov_mask;
    logic mode_indep;
    logic [7:0] wd_cfg;
    logic wd_flag;
    logic rst_asserted;

    wire wr_cfg = reg_wr && (reg_addr == `RO_ADDR_CFG);
    wire wr_status = reg_wr && (reg_addr == `RO_ADDR_STATUS);
    wire sw_clear = reg_wr && (reg_addr == `RO_ADDR_WDCLR) && reg_wdata[`RO_WDCLR_BIT];
    wire soft_trig = cfg[`RO_CFG_SOFT];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= `RO_CFG_RST;
            uv_mask <= 6'(`RO_MASK_RST);
            ov_mask <= 6'(`RO_MASK_RST);
            mode_indep <= 1'(`RO_MODE_RST >> `RO_MODE_INDEP);
            wd_cfg <= `RO_WDCFG_RST;
        end else begin
            if (wr_cfg)
                cfg <= {reg_wdata[7:2], 1'b0, reg_wdata[0]};
            else if (soft_trig)
                cfg[`RO_CFG_SOFT] <= 1'b0;
            if (reg_wr && reg_addr == `RO_ADDR_UV)
                uv_mask <= reg_wdata[5:0];
            if (reg_wr && reg_addr == `RO_ADDR_OV)
                ov_mask <= reg_wdata[5:0];
            if (reg_wr && reg_addr == `RO_ADDR_MODE)
                mode_indep <= reg_wdata[`RO_MODE_INDEP];
            if (reg_wr && reg_addr == `RO_ADDR_WDCFG)
                wd_cfg <= reg_wdata;
        end
    end

    wire [7:0] rd_mux =
        (reg_addr == `RO_ADDR_STATUS) ? {6'h00, wd_flag, rst_asserted} :
        (reg_addr == `RO_ADDR_CFG) ? cfg :
        (reg_addr == `RO_ADDR_UV) ? {2'h0, uv_mask} :
        (reg_addr == `RO_ADDR_OV) ? {2'h0, ov_mask} :
        (reg_addr == `RO_ADDR_MODE) ? {3'h0, mode_indep, 4'h0} :
        (reg_addr == `RO_ADDR_WDCFG) ? wd_cfg : 8'h00;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= rd_mux;
    end

    // reset output path
    wire pu_complete = last_slot_delay_done &&
        ((last_slot_channels & ~monitored_channel_above_uv) == 6'h00);
    wire uv_trip = |(monitored_channel_uv_fault & uv_mask);
    wire ov_trip = |(monitored_channel_ov_fault & ov_mask);
    wire crit_trip = |monitored_channel_critical;
    wire mon_trip = pu_complete && (uv_trip || ov_trip || crit_trip);
    wire rst_hold = !pu_complete || power_down_active || mon_trip ||
        soft_reboot || !mr_s2;

    logic [19:0] rp_cnt;
    logic by_wd;
    logic wd_fire;
    wire wd_rst_fire = wd_fire && tick;
    wire [19:0] rp_len = rp_us(cfg[7:4]);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            rp_cnt <= 20'h00000;
        else if (rst_hold || soft_trig || wd_rst_fire)
            rp_cnt <= rp_len;
        else if (tick && rp_cnt != 20'h00000)
            rp_cnt <= rp_cnt - 20'h00001;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_asserted <= 1'b1;
            by_wd <= 1'b0;
        end else begin
            rst_asserted <= rst_hold || soft_trig || wd_rst_fire || (rp_cnt != 20'h00000);
            if (wd_rst_fire)
                by_wd <= 1'b1;
            else if (rp_cnt == 20'h00000)
                by_wd <= 1'b0;
        end
    end

    // open drain drives only the low level, asserted or not
    wire pin_level = rst_asserted ^ !cfg[`RO_CFG_POL];
    wire pin_pp = cfg[`RO_CFG_PP];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reset_pin_out <= 1'b0;
            reset_pin_oe <= 1'b1;
        end else begin
            reset_pin_out <= pin_pp ? pin_level : 1'b0;
            reset_pin_oe <= pin_pp || !pin_level;
        end
    end

    // watchdog
    ro_pkg::ro_wd_state_t wd_state, next_state;
    logic [28:0] wd_cnt, next_cnt;
    wire [28:0] wd_len = wd_us(wd_cfg[3:0]);
    wire [28:0] st_len = start_us(wd_cfg[6:4]);
    wire restart = kick_edge || sw_clear;
    wire dep_hold = rst_asserted || !pu_complete;
    wire ind_hold = !supply_ok || !boot_done || by_wd;
    wire wd_hold = !en_s2 || (wd_len == 29'd0) ||
        (mode_indep ? ind_hold : dep_hold);
    wire cnt_end = tick && (wd_cnt + 29'd1 >= (wd_state == ro_pkg::RO_WD_START ? st_len : wd_len));

    always_comb begin
        next_state = wd_state;
        next_cnt = wd_cnt;
        if (wd_hold) begin
            next_state = ro_pkg::RO_WD_OFF;
            next_cnt = 29'd0;
        end else begin
            case (wd_state)
                ro_pkg::RO_WD_OFF: begin
                    next_state = (st_len != 29'd0) ? ro_pkg::RO_WD_START :
                        ro_pkg::RO_WD_RUN;
                    next_cnt = 29'd0;
                end
                ro_pkg::RO_WD_START, ro_pkg::RO_WD_RUN: begin
                    if (restart) begin
                        next_state = ro_pkg::RO_WD_RUN;
                        next_cnt = 29'd0;
                    end else if (cnt_end) begin
                        next_state = ro_pkg::RO_WD_EXP;
                        next_cnt = 29'd0;
                    end else if (tick) begin
                        next_cnt = wd_cnt + 29'd1;
                    end
                end
                ro_pkg::RO_WD_EXP: begin
                    if (restart)
                        next_state = ro_pkg::RO_WD_RUN;
                end
                default: begin
                    next_state = ro_pkg::RO_WD_OFF;
                    next_cnt = 29'd0;
                end
            endcase
        end
    end

    wire expiry = (next_state == ro_pkg::RO_WD_EXP) && (wd_state != ro_pkg::RO_WD_EXP);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wd_state <= ro_pkg::RO_WD_OFF;
            wd_cnt <= 29'd0;
            watchdog_expiry_output_n <= 1'b1;
        end else begin
            wd_state <= next_state;
            wd_cnt <= next_cnt;
            watchdog_expiry_output_n <= (next_state != ro_pkg::RO_WD_EXP);
        end
    end

    // reset follows expiry one tick later so the expiry output shows for about 1us
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            wd_fire <= 1'b0;
        else if (expiry && wd_cfg[`RO_WD_RSTEN])
            wd_fire <= 1'b1;
        else if (tick || wd_hold)
            wd_fire <= 1'b0;
    end

    // a new watchdog reset wins over a software clear in the same cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            wd_flag <= 1'b0;
        else if (wd_rst_fire)
            wd_flag <= 1'b1;
        else if (wr_status && reg_wdata[`RO_ST_WDFLAG])
            wd_flag <= 1'b0;
    end

    // checks
    rst_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rst_hold |=> rst_asserted) else $error("reset not held");
    rst_release_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(rst_asserted) |-> $past(rp_cnt) == 20'h00001 || $past(rp_cnt) == 20'h00000)
        else $error("reset released early");
    pu_empty_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        last_slot_delay_done && last_slot_channels == 6'h00 && !power_down_active &&
        !soft_reboot && mr_s2 && !mon_trip && !soft_trig && !wd_rst_fire &&
        rp_cnt == 20'h00000 |=> !rst_asserted)
        else $error("empty slot not complete");
    uv_mask_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        pu_complete && uv_trip |=> rst_asserted ##1 reset_pin_out == cfg[`RO_CFG_POL]
        || !pin_pp) else $error("undervoltage missed");
    ov_mask_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        pu_complete && ov_trip |=> rst_asserted) else $error("overvoltage missed");
    crit_trip_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        pu_complete && crit_trip |=> rst_asserted) else $error("critical missed");
    open_drain_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !$past(pin_pp) |-> !(reset_pin_oe && reset_pin_out)) else $error("od drives high");
    soft_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        soft_trig && !wr_cfg |=> !soft_trig && rst_asserted) else $error("soft trigger");
    status_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_rd && reg_addr == `RO_ADDR_STATUS |=> reg_rdata[0] == $past(rst_asserted))
        else $error("status mismatch");
    dep_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !mode_indep && rst_asserted |=> wd_state == ro_pkg::RO_WD_OFF ##1
        watchdog_expiry_output_n || !rst_asserted) else $error("watchdog not held");
    en_low_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !en_s2 |=> wd_state == ro_pkg::RO_WD_OFF) else $error("enable low ignored");
    kick_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wd_state == ro_pkg::RO_WD_EXP && kick_edge && !wd_hold |=> ##1 watchdog_expiry_output_n)
        else $error("kick not clearing");
    flag_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wd_rst_fire |=> wd_flag && rst_asserted) else $error("flag not set");

    soft_pulse_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
        soft_trig ##1 rst_asserted);
    wd_expire_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
        expiry ##[1:400] wd_rst_fire);
    start_run_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
        wd_state == ro_pkg::RO_WD_START ##1 wd_state == ro_pkg::RO_WD_RUN);

endmodule : ro_reset_wdog

/* File: rtl/ro_cfg.svh */
`ifndef RO_CFG_SVH
`define RO_CFG_SVH
`define RO_CLK_NS 5
`define RO_TICK_NS 1000
`define RO_ADDR_STATUS 8'h20
`define RO_ADDR_CFG 8'h3B
`define RO_ADDR_UV 8'h3C
`define RO_ADDR_OV 8'h3D
`define RO_ADDR_MODE 8'h73
`define RO_ADDR_WDCLR 8'h75
`define RO_ADDR_WDCFG 8'h76
`define RO_CFG_SOFT 0
`define RO_CFG_POL 2
`define RO_CFG_PP 3
`define RO_ST_RST 0
`define RO_ST_WDFLAG 1
`define RO_MODE_INDEP 4
`define RO_WDCLR_BIT 5
`define RO_WD_RSTEN 7
`define RO_CFG_RST 8'h00
`define RO_MASK_RST 8'h00
`define RO_MODE_RST 8'h00
`define RO_WDCFG_RST 8'h00
`endif

/* File: rtl/ro_pkg.sv */
package ro_pkg;
    typedef enum logic [1:0] {
        RO_WD_OFF = 2'b00,
        RO_WD_START = 2'b01,
        RO_WD_RUN = 2'b11,
        RO_WD_EXP = 2'b10
    } ro_wd_state_t;
endpackage : ro_pkg

/* File: verif/ro_kick_host.sv */
`timescale 1ns/1ps
module ro_kick_host (
    input wire logic sys_clk,
    input wire logic kick_run,
    input wire logic kick_once,
    input wire logic [15:0] kick_period,
    output logic watchdog_kick_input
);
    logic [15:0] count;
    initial begin
        watchdog_kick_input = 1'b0;
        count = 16'h0000;
    end
    // both edges count as a kick, so a plain toggle is all a healthy processor does
    always @(negedge sys_clk) begin
        if (kick_once || (kick_run && count >= kick_period)) begin
            watchdog_kick_input <= ~watchdog_kick_input;
            count <= 16'h0000;
        end else if (kick_run) begin
            count <= count + 16'h0001;
        end else begin
            count <= 16'h0000;
        end
    end
endmodule : ro_kick_host

/* File: verif/reset_output_and_watchdog_test.sv */
`timescale 1ns/1ps
module reset_output_and_watchdog_test;
    localparam int TICK = 2;
    localparam int TO = 1000 * TICK;
    localparam int RP = 25 * TICK;
    localparam logic [30:0] FT [5] = '{
        {6'h04, 6'h00, 6'h04, 6'h00, 6'h00, 1'b1},
        {6'h04, 6'h00, 6'h08, 6'h00, 6'h00, 1'b0},
        {6'h00, 6'h20, 6'h00, 6'h20, 6'h00, 1'b1},
        {6'h00, 6'h20, 6'h00, 6'h10, 6'h00, 1'b0},
        {6'h00, 6'h00, 6'h02, 6'h00, 6'h02, 1'b1}};
    logic sys_clk, rst_n, reg_wr, reg_rd, power_down_active, last_slot_delay_done;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [5:0] last_slot_channels, monitored_channel_above_uv, monitored_channel_uv_fault;
    logic [5:0] monitored_channel_ov_fault, monitored_channel_critical, uvm, ovm, uvf, ovf, crit;
    logic supply_ok, boot_done, soft_reboot, manual_reset_input_n, enable_input;
    logic watchdog_kick_input, reset_pin_out, reset_pin_oe, watchdog_expiry_output_n;
    logic kick_run, kick_once, pol, e, bad;
    int num_errors, total_checks, n;

    ro_reset_wdog #(.TICK_CYCLES(TICK)) u_ro_reset_wdog (.sys_clk, .rst_n, .reg_wr, .reg_rd,
        .reg_addr, .reg_wdata, .reg_rdata, .power_down_active, .last_slot_delay_done,
        .last_slot_channels, .monitored_channel_above_uv, .monitored_channel_uv_fault,
        .monitored_channel_ov_fault, .monitored_channel_critical, .supply_ok, .boot_done,
        .soft_reboot, .manual_reset_input_n, .enable_input, .watchdog_kick_input,
        .reset_pin_out, .reset_pin_oe, .watchdog_expiry_output_n);
    ro_kick_host u_ro_kick_host (.sys_clk, .kick_run, .kick_once, .kick_period(16'h05DC),
        .watchdog_kick_input);

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // released pin reads as pulled up, so open-drain active-high shows asserted
    function automatic logic sig(input logic sel);
        return sel ? watchdog_expiry_output_n : (reset_pin_oe ? reset_pin_out : 1'b1) == pol;
    endfunction : sig

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_n(input int lo, input int hi);
        total_checks++;
        if (n < lo || n > hi) begin
            num_errors++;
            $display("[FAIL] %0t took %0d cycles, window %0d..%0d", $time, n, lo, hi);
        end
    endtask : chk_n

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge sys_clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        @(negedge sys_clk);
        chk(reg_rdata, exp);
    endtask : rd

    task automatic wait_sig(input logic sel, input logic v, input int lim);
        n = 0;
        while (sig(sel) !== v && n < lim) begin
            @(negedge sys_clk);
            n++;
        end
        chk({7'h00, sig(sel)}, {7'h00, v});
    endtask : wait_sig

    task automatic hold(input logic sel, input logic v, input int cyc);
        bad = 1'b0;
        repeat (cyc) begin
            @(negedge sys_clk);
            if (sig(sel) !== v) bad = 1'b1;
        end
        chk({7'h00, bad}, 8'h00);
    endtask : hold

    task automatic kick();
        @(negedge sys_clk);
        kick_once <= 1'b1;
        @(negedge sys_clk);
        kick_once <= 1'b0;
    endtask : kick

    task automatic finish_test();
        if (num_errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (60000) @(posedge sys_clk);
        num_errors++;
        finish_test();
    end

    initial begin
        {num_errors, total_checks, pol, rst_n, reg_wr, reg_rd} = '0;
        {reg_addr, reg_wdata, power_down_active, last_slot_delay_done, soft_reboot} = '0;
        {monitored_channel_above_uv, monitored_channel_uv_fault} = '0;
        {monitored_channel_ov_fault, monitored_channel_critical} = '0;
        {supply_ok, boot_done, manual_reset_input_n, enable_input} = 4'hF;
        last_slot_channels = 6'h01;
        kick_run = 1'b0;
        kick_once = 1'b0;
        repeat (4) @(negedge sys_clk);
        rst_n = 1'b1;
        chk({5'h00, reset_pin_oe, reset_pin_out, watchdog_expiry_output_n}, 8'h05);
        foreach (FT[i]) rd(8'h3B + 8'(i), 8'h00);
        rd(8'h55, 8'h00);
        last_slot_delay_done = 1'b1;
        hold(0, 1, 200);
        monitored_channel_above_uv = 6'h01;
        wait_sig(0, 0, RP + 20);
        chk_n(RP - TICK, RP + 8);
        foreach (FT[i]) begin
            {uvm, ovm, uvf, ovf, crit, e} = FT[i];
            wr(8'h3C, {2'h0, uvm});
            wr(8'h3D, {2'h0, ovm});
            rd(8'h3D, {2'h0, ovm});
            {monitored_channel_uv_fault, monitored_channel_ov_fault} = {uvf, ovf};
            monitored_channel_critical = crit;
            repeat (6) @(negedge sys_clk);
            chk({7'h00, sig(0)}, {7'h00, e});
            {monitored_channel_uv_fault, monitored_channel_ov_fault} = '0;
            monitored_channel_critical = 6'h00;
            wait_sig(0, 0, RP + 20);
        end
        soft_reboot = 1'b1;
        repeat (6) @(negedge sys_clk);
        chk({7'h00, sig(0)}, 8'h01);
        soft_reboot = 1'b0;
        wait_sig(0, 0, RP + 20);
        for (int c = 0; c < 4; c++) begin
            wr(8'h3B, {4'h0, 2'(c), 2'b00});
            pol = c[0];
            repeat (3) @(negedge sys_clk);
            chk({6'h00, reset_pin_oe, reset_pin_out & reset_pin_oe},
                {6'h00, c[1] | c[0], ~c[0] & c[1]});
            wr(8'h3B, {4'h0, 2'(c), 2'b01});
            repeat (3) @(negedge sys_clk);
            chk({6'h00, reset_pin_oe, reset_pin_out & reset_pin_oe},
                {6'h00, c[1] | ~c[0], c[0] & c[1]});
            rd(8'h3B, {4'h0, 2'(c), 2'b00});
            wait_sig(0, 0, RP + 20);
        end
        wr(8'h3B, 8'h11);
        pol = 1'b0;
        rd(8'h20, 8'h01);
        wait_sig(0, 0, 1600 * TICK);
        chk_n(1500 * TICK - 12, 1500 * TICK + 8);
        wr(8'h3B, 8'h00);
        rd(8'h20, 8'h00);
        wr(8'h76, 8'h01);
        kick_run <= 1'b1;
        hold(1, 1, 5000);
        kick_run <= 1'b0;
        kick();
        repeat (1500) @(negedge sys_clk);
        wr(8'h75, 8'h20);
        hold(1, 1, 1500);
        wait_sig(1, 0, 700);
        kick();
        wait_sig(1, 1, 8);
        wait_sig(1, 0, TO + 200);
        chk_n(TO - 2, TO + 12);
        hold(1, 0, 100);
        chk({7'h00, sig(0)}, 8'h00);
        kick();
        wait_sig(1, 1, 8);
        enable_input = 1'b0;
        hold(1, 1, TO + 400);
        enable_input = 1'b1;
        wait_sig(1, 0, TO + 200);
        power_down_active = 1'b1;
        wait_sig(1, 1, 8);
        hold(1, 1, TO + 400);
        power_down_active = 1'b0;
        wait_sig(0, 0, RP + 20);
        wr(8'h76, 8'h81);
        kick();
        wait_sig(1, 0, TO + 200);
        wait_sig(1, 1, 4 * TICK + 6);
        chk({7'h00, sig(0)}, 8'h01);
        rd(8'h20, 8'h03);
        wr(8'h20, 8'h02);
        wait_sig(0, 0, RP + 20);
        rd(8'h20, 8'h00);
        wr(8'h76, 8'h11);
        manual_reset_input_n = 1'b0;
        repeat (10) @(negedge sys_clk);
        manual_reset_input_n = 1'b1;
        wait_sig(0, 0, RP + 40);
        hold(1, 1, TO + 400);
        kick();
        wait_sig(1, 0, TO + 200);
        chk_n(TO - 2, TO + 12);
        kick();
        wait_sig(1, 1, 8);
        wr(8'h73, 8'h10);
        rd(8'h73, 8'h10);
        wr(8'h76, 8'h01);
        kick();
        power_down_active = 1'b1;
        wait_sig(1, 0, TO + 200);
        chk_n(TO - 2, TO + 12);
        power_down_active = 1'b0;
        kick();
        wait_sig(1, 1, 8);
        supply_ok = 1'b0;
        hold(1, 1, TO + 400);
        {supply_ok, boot_done} = 2'b10;
        hold(1, 1, TO + 400);
        boot_done = 1'b1;
        wait_sig(1, 0, TO + 200);
        chk_n(TO - 2, TO + 12);
        rst_n = 1'b0;
        {last_slot_channels, monitored_channel_above_uv, last_slot_delay_done} = '0;
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        hold(0, 1, 100);
        last_slot_delay_done = 1'b1;
        wait_sig(0, 0, RP + 20);
        chk_n(RP - TICK, RP + 8);
        finish_test();
    end
endmodule : reset_output_and_watchdog_test
